// ==== core/byte_fifo.sv ====
`timescale 1ns/1ps
module byte_fifo
	import sonet_tx_pkg::*;
#(
	parameter int W = FIFO_W,
	parameter int D = FIFO_D
) (
	// Clock and reset
	input  wire logic         clock_i,
	input  wire logic         sys_rst_i,
	// Fill side
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	// Drain side
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int AW = $clog2(D);

	if (D < 2 || (1 << AW) != D || W < 1)
	begin : g_bad
		$error("byte_fifo: depth must be a power of two, at least 2");
	end

	logic [W-1:0] mem_q [D];
	logic [AW:0]  wp_q;
	logic [AW:0]  rp_q;

	wire full  = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
	wire empty = wp_q == rp_q;
	wire push  = in_valid_i && !full;
	wire pop   = out_ready_i && !empty;

	assign in_ready_o  = !full;
	assign out_valid_o = !empty;
	assign out_data_o  = mem_q[rp_q[AW-1:0]];

	always_ff @(posedge clock_i)
	begin
		if (push)
			mem_q[wp_q[AW-1:0]] <= in_data_i;
	end

	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			wp_q <= '0;
			rp_q <= '0;
		end
		else
		begin
			wp_q <= wp_q + (AW+1)'(push);
			rp_q <= rp_q + (AW+1)'(pop);
		end
	end

endmodule : byte_fifo

// ==== core/cell_tx_proc.sv ====
`timescale 1ns/1ps
module cell_tx_proc
	import sonet_tx_pkg::*;
(
	// Clock and reset
	input  wire logic        clock_i,
	input  wire logic        sys_rst_i,
	// Control
	input  wire logic        active_i,
	input  wire logic        test_en_i,
	input  wire logic        gfc_en_i,
	input  wire logic [31:0] test_hdr_i,
	// Upstream cell buffer
	input  wire logic        up_avail_i,
	input  wire logic [7:0]  up_data_i,
	output logic             up_take_o,
	// Processed bytes
	output logic             out_valid_o,
	input  wire logic        out_ready_i,
	output logic [7:0]       out_data_o,
	// Statistics
	output cell_cnt_t        cnt_o
);
	logic [5:0]  pos_q;
	cell_src_t   src_q;
	cell_src_t   src_now;
	logic [7:0]  crc_q;
	logic [42:0] scr_q;
	logic [7:0]  raw;
	logic [7:0]  hdr_b;
	logic [7:0]  pay_b;

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c;
		for (int i = 7; i >= 0; i--)
			r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? HEC_POLY : 8'h00);
		return r;
	endfunction : crc8

	// Self-synchronising: history holds the last 43 sent bits
	function automatic logic [50:0] scr43(input logic [42:0] h, input logic [7:0] d);
		logic [42:0] s;
		logic [7:0]  o;
		s = h;
		o = 8'h00;
		for (int i = 7; i >= 0; i--)
		begin
			o[i] = d[i] ^ s[42];
			s = {s[41:0], o[i]};
		end
		return {s, o};
	endfunction : scr43

	wire        start  = pos_q == 6'd0;
	wire        fire   = active_i && out_ready_i;
	wire        is_hdr = pos_q < HEC_POS;
	wire        is_hec = pos_q == HEC_POS;
	wire [1:0]  hsel   = 2'd3 - pos_q[1:0];
	wire [7:0]  crc_in = start ? 8'h00 : crc_q;
	wire [50:0] scr_r  = scr43(scr_q, raw);

	// Source fixed for the whole cell at its first byte
	assign src_now = !start ? src_q :
		(up_avail_i && !gfc_en_i) ? SRC_USER :
		test_en_i ? SRC_TEST : SRC_IDLE;

	always_comb
	begin
		case (src_now)
			SRC_USER:
			begin
				hdr_b = up_data_i;
				pay_b = up_data_i;
			end
			SRC_TEST:
			begin
				hdr_b = test_hdr_i[{hsel, 3'b000} +: 8];
				pay_b = crc_q ^ {2'b00, pos_q};
			end
			default:
			begin
				hdr_b = IDLE_HDR[{hsel, 3'b000} +: 8];
				pay_b = IDLE_PAY;
			end
		endcase
		raw = is_hdr ? hdr_b : pay_b;
	end

	// Header stays clear; HEC goes out in the fifth byte
	assign out_data_o  = is_hdr ? raw : is_hec ? crc_q ^ HEC_COSET : scr_r[7:0];
	assign out_valid_o = active_i;
	assign up_take_o   = fire && src_now == SRC_USER && !is_hec;

	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			pos_q <= 6'd0;
			src_q <= SRC_IDLE;
			crc_q <= 8'h00;
			scr_q <= '0;
			cnt_o <= '0;
		end
		else if (fire)
		begin
			pos_q <= (pos_q == CELL_LAST) ? 6'd0 : pos_q + 6'd1;
			src_q <= src_now;
			if (is_hdr)
				crc_q <= crc8(crc_in, raw);
			if (!is_hdr && !is_hec)
				scr_q <= scr_r[50:8];
			if (pos_q == CELL_LAST && src_q == SRC_USER)
				cnt_o.assigned <= cnt_o.assigned + 16'd1;
			if (pos_q == CELL_LAST && src_q == SRC_IDLE)
				cnt_o.idle <= cnt_o.idle + 16'd1;
		end
	end

endmodule : cell_tx_proc

// ==== core/sonet_tx_framer.sv ====
`timescale 1ns/1ps
module sonet_tx_framer
	import sonet_tx_pkg::*;
#(
	parameter int BUF_DEPTH = FIFO_D
) (
	// Clock and reset
	input  wire logic              clock_i,
	input  wire logic              sys_rst_i,
	// Configuration
	input  wire logic              conc_mode_i,
	input  wire logic [3:0]        test_en_i,
	input  wire logic [3:0]        gfc_en_i,
	input  wire logic [3:0][31:0]  test_hdr_i,
	// Alarm commands and receive-side alarms
	input  wire alarm_cmd_t        alarm_cmd_i,
	input  wire logic              rx_line_alarm_i,
	input  wire logic              rx_path_alarm_i,
	// Upstream cell buffers
	input  wire logic [3:0]        cell_avail_i,
	input  wire logic [3:0][7:0]   cell_data_i,
	output logic [3:0]             cell_take_o,
	// Line side
	output logic [7:0]             line_data_o,
	output logic                   frame_pulse_o,
	// Statistics
	output cell_cnt_t [3:0]        cell_cnt_o
);
	logic [3:0]       row_q;
	logic [10:0]      col_q;
	logic [3:0]       m12_q;
	logic [6:0]       fs_q;
	logic [7:0]       b1_q;
	logic [7:0]       b1_acc_q;
	logic [7:0]       b2_q [STS1_CNT];
	logic [7:0]       b2_acc_q [STS1_CNT];
	logic [7:0]       b3_q [CH_CNT];
	logic [7:0]       b3_acc_q [CH_CNT];
	logic [3:0]       ch_active;
	logic [3:0]       fifo_pop;
	logic [3:0]       fifo_valid;
	logic [3:0][7:0]  fifo_data;
	logic [3:0]       proc_valid;
	logic [3:0]       proc_ready;
	logic [3:0][7:0]  proc_data;
	logic [7:0]       toh_b;
	logic [7:0]       poh_b;
	logic [7:0]       raw;

	// Counters and interleave below serve this geometry only
	localparam int SOH_BYTES = int'(ROW_LINE) * int'(TOH_COLS);
	localparam int LOH_BYTES = (ROWS - int'(ROW_LINE)) * int'(TOH_COLS);
	if (ROWS * COLS != 32'h0000_25F8 || ROWS * int'(TOH_COLS) != 32'h0000_0144)
	begin : g_bad_frame
		$error("sonet_tx_framer: frame must be 9720 bytes with 324 overhead bytes");
	end
	if (SOH_BYTES != 32'h0000_006C || LOH_BYTES != 32'h0000_00D8)
	begin : g_bad_toh
		$error("sonet_tx_framer: section and line overhead split is wrong");
	end
	if (COLS % STS1_CNT != 32'h0000_0000 || STS1_CNT % CH_CNT != 32'h0000_0000 || int'(PTR_CNT) != CH_CNT)
	begin : g_bad_interleave
		$error("sonet_tx_framer: columns must hold whole STS-1 and channel interleaves");
	end
	if (int'(COL_LAST) != COLS - 1 || int'(ROW_LAST) != ROWS - 1 || int'(M12_LAST) != STS1_CNT - 1)
	begin : g_bad_last
		$error("sonet_tx_framer: last row, column or STS-1 index disagrees with the size");
	end
	if (int'(COL_SCR) != int'(TOH_COLS) - 1)
	begin : g_bad_reload
		$error("sonet_tx_framer: scrambler reload must fall just before the envelope");
	end
	// All-zero seed would leave the frame scrambler stuck at zero
	if (FSCR_SEED == 7'h00)
	begin : g_bad_seed
		$error("sonet_tx_framer: frame scrambler seed must not be zero");
	end

	// Cell path: one processor and one buffer per channel
	assign ch_active = conc_mode_i ? 4'b0001 : 4'b1111;

	for (genvar i = 0; i < CH_CNT; i++)
	begin : g_ch
		cell_tx_proc u_proc (
			.clock_i     (clock_i),
			.sys_rst_i   (sys_rst_i),
			.active_i    (ch_active[i]),
			.test_en_i   (test_en_i[i]),
			.gfc_en_i    (gfc_en_i[i]),
			.test_hdr_i  (test_hdr_i[i]),
			.up_avail_i  (cell_avail_i[i]),
			.up_data_i   (cell_data_i[i]),
			.up_take_o   (cell_take_o[i]),
			.out_valid_o (proc_valid[i]),
			.out_ready_i (proc_ready[i]),
			.out_data_o  (proc_data[i]),
			.cnt_o       (cell_cnt_o[i])
		);

		// Processor stalls on a full buffer; the framer drains at line rate
		byte_fifo #(
			.W (FIFO_W),
			.D (BUF_DEPTH)
		) u_fifo (
			.clock_i     (clock_i),
			.sys_rst_i   (sys_rst_i),
			.in_valid_i  (proc_valid[i]),
			.in_ready_o  (proc_ready[i]),
			.in_data_i   (proc_data[i]),
			.out_valid_o (fifo_valid[i]),
			.out_ready_i (fifo_pop[i]),
			.out_data_o  (fifo_data[i])
		);
	end

	// Frame position decode
	wire        row_last  = row_q == ROW_LAST;
	wire        col_last  = col_q == COL_LAST;
	wire        in_toh    = col_q < TOH_COLS;
	wire [10:0] spe_col   = col_q - TOH_COLS;
	wire        in_poh    = !in_toh && (conc_mode_i ? spe_col == 11'd0 : spe_col < 11'd4);
	wire        in_stuff  = !in_toh && conc_mode_i && spe_col != 11'd0 && spe_col < 11'd4;
	wire        in_pay    = !in_toh && !in_poh && !in_stuff;
	wire [1:0]  pay_ch    = conc_mode_i ? 2'd0 : m12_q[1:0];
	wire        ptr_first = conc_mode_i ? m12_q == 4'd0 : m12_q < PTR_CNT;
	wire        frame_beg = row_q == 4'd0 && col_q == 11'd0;
	wire        section   = in_toh && row_q < ROW_LINE;
	wire        scr_on    = !(row_q == 4'd0 && in_toh);

	// Alarm sources
	wire        l_ais     = alarm_cmd_i.line_ais;
	wire        p_ais     = alarm_cmd_i.path_ais;
	wire        l_rdi     = alarm_cmd_i.line_rdi || rx_line_alarm_i;
	wire        p_rdi     = alarm_cmd_i.path_rdi || rx_path_alarm_i;

	// Drain keeps running under AIS so the cell rate stays locked
	assign fifo_pop = in_pay ? (4'b0001 << pay_ch) : 4'b0000;
	wire [7:0]  head_b    = fifo_valid[pay_ch] ? fifo_data[pay_ch] : IDLE_PAY;

	wire [7:0]  h1_b      = p_ais ? ALL_ONES : ptr_first ? PTR_H1 : CONC_H1;
	wire [7:0]  h2_b      = p_ais ? ALL_ONES : ptr_first ? PTR_H2 : CONC_H2;

	// Transport overhead
	always_comb
	begin
		toh_b = 8'h00;
		case (row_q)
			4'd0:
			begin
				if (col_q < COL_A2)
					toh_b = A1_VAL;
				else if (col_q < COL_END2)
					toh_b = A2_VAL;
			end
			ROW_B1:
			begin
				if (col_q == 11'd0)
					toh_b = b1_q;
			end
			ROW_PTR:
			begin
				if (col_q < COL_A2)
					toh_b = h1_b;
				else if (col_q < COL_END2)
					toh_b = h2_b;
			end
			ROW_B2:
			begin
				if (col_q < COL_K1)
					toh_b = b2_q[m12_q];
				else if (col_q == COL_K2 && l_rdi)
					toh_b = K2_RDI;
			end
			default:
				toh_b = 8'h00;
		endcase
	end

	// Path overhead, one column per channel
	always_comb
	begin
		case (row_q)
			ROW_B3:
				poh_b = b3_q[pay_ch];
			ROW_C2:
				poh_b = C2_ATM;
			ROW_G1:
				poh_b = p_rdi ? G1_RDI : 8'h00;
			default:
				poh_b = 8'h00;
		endcase
	end

	// Line AIS overrides everything after the section rows
	always_comb
	begin
		if (l_ais && row_q >= ROW_LINE)
			raw = ALL_ONES;
		else if (in_toh)
			raw = toh_b;
		else if (p_ais)
			raw = ALL_ONES;
		else if (in_poh)
			raw = poh_b;
		else if (in_stuff)
			raw = STUFF_VAL;
		else
			raw = head_b;
	end

	// x7+x6+1 frame scrambler, byte-serial MSB first
	function automatic logic [14:0] fscr(input logic [6:0] s, input logic [7:0] d);
		logic [6:0] t;
		logic [7:0] o;
		t = s;
		o = 8'h00;
		for (int i = 7; i >= 0; i--)
		begin
			o[i] = d[i] ^ t[6];
			t = {t[5:0], t[6] ^ t[5]};
		end
		return {t, o};
	endfunction : fscr

	wire [14:0] fs_r     = fscr(fs_q, raw);
	wire [7:0]  line_b   = scr_on ? fs_r[7:0] : raw;

	// Position counters and frame scrambler state
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			row_q <= 4'd0;
			col_q <= 11'd0;
			m12_q <= 4'd0;
			fs_q  <= FSCR_SEED;
		end
		else
		begin
			col_q <= col_last ? 11'd0 : col_q + 11'd1;
			m12_q <= (m12_q == M12_LAST) ? 4'd0 : m12_q + 4'd1;
			if (col_last)
				row_q <= row_last ? 4'd0 : row_q + 4'd1;
			if (row_q == 4'd0 && col_q == COL_SCR)
				fs_q <= FSCR_SEED;
			else if (scr_on)
				fs_q <= fs_r[14:8];
		end
	end

	// Line outputs
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			line_data_o   <= 8'h00;
			frame_pulse_o <= 1'b0;
		end
		else
		begin
			line_data_o   <= line_b;
			frame_pulse_o <= frame_beg;
		end
	end

	// B1 over scrambled frame, latched at each frame start
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			b1_q     <= 8'h00;
			b1_acc_q <= 8'h00;
		end
		else if (frame_beg)
		begin
			b1_q     <= b1_acc_q;
			b1_acc_q <= line_b;
		end
		else
			b1_acc_q <= b1_acc_q ^ line_b;
	end

	// B2 per STS-1 over line overhead and envelope, before scrambling
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			b2_q     <= '{default: 8'h00};
			b2_acc_q <= '{default: 8'h00};
		end
		else if (frame_beg)
		begin
			b2_q     <= b2_acc_q;
			b2_acc_q <= '{default: 8'h00};
		end
		else if (!section)
			b2_acc_q[m12_q] <= b2_acc_q[m12_q] ^ raw;
	end

	// B3 per channel over its envelope bytes
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			b3_q     <= '{default: 8'h00};
			b3_acc_q <= '{default: 8'h00};
		end
		else if (frame_beg)
		begin
			b3_q     <= b3_acc_q;
			b3_acc_q <= '{default: 8'h00};
		end
		else if (!in_toh)
			b3_acc_q[pay_ch] <= b3_acc_q[pay_ch] ^ raw;
	end

endmodule : sonet_tx_framer

// ==== core/sonet_tx_pkg.sv ====
package sonet_tx_pkg;

	// Frame geometry, byte-interleaved STS-12
	localparam int          ROWS      = 9;
	localparam int          COLS      = 1080;
	localparam int          STS1_CNT  = 12;
	localparam int          CH_CNT    = 4;
	localparam logic [3:0]  ROW_LAST  = 4'd8;
	localparam logic [10:0] COL_LAST  = 11'd1079;
	localparam logic [10:0] TOH_COLS  = 11'd36;
	localparam logic [3:0]  M12_LAST  = 4'd11;
	localparam logic [3:0]  PTR_CNT   = 4'd4;

	// Overhead rows and columns
	localparam logic [3:0]  ROW_B1    = 4'd1;
	localparam logic [3:0]  ROW_PTR   = 4'd3;
	localparam logic [3:0]  ROW_B2    = 4'd4;
	localparam logic [3:0]  ROW_LINE  = 4'd3;
	localparam logic [3:0]  ROW_B3    = 4'd1;
	localparam logic [3:0]  ROW_C2    = 4'd2;
	localparam logic [3:0]  ROW_G1    = 4'd3;
	localparam logic [10:0] COL_A2    = 11'd12;
	localparam logic [10:0] COL_END2  = 11'd24;
	localparam logic [10:0] COL_K1    = 11'd12;
	localparam logic [10:0] COL_K2    = 11'd24;
	localparam logic [10:0] COL_SCR   = 11'd35;

	// Overhead values
	localparam logic [7:0]  A1_VAL    = 8'hF6;
	localparam logic [7:0]  A2_VAL    = 8'h28;
	localparam logic [7:0]  PTR_H1    = 8'h62;
	localparam logic [7:0]  PTR_H2    = 8'h0A;
	localparam logic [7:0]  CONC_H1   = 8'h93;
	localparam logic [7:0]  CONC_H2   = 8'hFF;
	localparam logic [7:0]  K2_RDI    = 8'h06;
	localparam logic [7:0]  C2_ATM    = 8'h13;
	localparam logic [7:0]  G1_RDI    = 8'h08;
	localparam logic [7:0]  ALL_ONES  = 8'hFF;
	localparam logic [7:0]  STUFF_VAL = 8'h00;
	localparam logic [6:0]  FSCR_SEED = 7'h7F;

	// Cell format
	localparam logic [5:0]  CELL_LAST = 6'd52;
	localparam logic [5:0]  HEC_POS   = 6'd4;
	localparam logic [7:0]  HEC_POLY  = 8'h07;
	localparam logic [7:0]  HEC_COSET = 8'h55;
	localparam logic [31:0] IDLE_HDR  = 32'h0000_0001;
	localparam logic [7:0]  IDLE_PAY  = 8'h6A;
	localparam int          FIFO_W    = 8;
	localparam int          FIFO_D    = 8;

	typedef enum logic [1:0] {SRC_USER, SRC_TEST, SRC_IDLE} cell_src_t;

	typedef struct packed {
		logic [15:0] assigned;
		logic [15:0] idle;
	} cell_cnt_t;

	typedef struct packed {
		logic path_ais;
		logic path_rdi;
		logic line_ais;
		logic line_rdi;
	} alarm_cmd_t;

endpackage : sonet_tx_pkg

// ==== sim/line_conv_model.sv ====
`timescale 1ns/1ps
module line_conv_model
	import sonet_tx_pkg::*;
(
	// Byte stream from the framer
	input  wire logic       clock_i,
	input  wire logic [7:0] line_data_i,
	input  wire logic       frame_pulse_i
);
	logic [7:0] cur_mem [0:9719];
	logic [7:0] frm_mem [0:9719];
	logic [6:0] scr;
	logic [7:0] d;
	int         pos    = 100000;
	int         frames = 0;

	// Only whole frames are published, so a partial first frame is never judged
	always @(posedge clock_i)
	begin
		if (frame_pulse_i)
		begin
			if (pos == 9720)
			begin
				frm_mem = cur_mem;
				frames++;
			end
			pos = 0;
		end
		if (pos == 36)
			scr = FSCR_SEED;
		d = line_data_i;
		if (pos >= 36)
			for (int b = 7; b >= 0; b--)
			begin
				d[b] = d[b] ^ scr[6];
				scr  = {scr[5:0], scr[6] ^ scr[5]};
			end
		if (pos < 9720)
			cur_mem[pos] = d;
		pos++;
	end
endmodule : line_conv_model

// ==== sim/sonet_tx_framer_sva.sv ====
`timescale 1ns/1ps
module sonet_tx_framer_chk
	import sonet_tx_pkg::*;
(
	// Clock and reset
	input  wire logic            clock_i,
	input  wire logic            sys_rst_i,
	// Watched ports
	input  wire logic            conc_mode_i,
	input  wire logic [3:0]      cell_take_o,
	input  wire logic [7:0]      line_data_o,
	input  wire logic            frame_pulse_o,
	input  wire cell_cnt_t [3:0] cell_cnt_o
);
	logic [13:0] gap_q;
	logic        armed_q;

	// Cycles since the last frame mark
	always_ff @(posedge clock_i)
	begin
		if (sys_rst_i)
		begin
			gap_q   <= 14'h0000;
			armed_q <= 1'b0;
		end
		else
		begin
			gap_q   <= frame_pulse_o ? 14'h0001 : gap_q + 14'h0001;
			armed_q <= armed_q | frame_pulse_o;
		end
	end

	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	a_frame_period: assert property (armed_q |-> (frame_pulse_o == (gap_q == 14'h25F8)))
		else $error("frame mark not every 9720 bytes");
	a_mark_on_a1: assert property (frame_pulse_o |-> line_data_o == A1_VAL)
		else $error("frame mark not on first A1");
	a_a1_run: assert property (frame_pulse_o |-> ##4 (line_data_o == A1_VAL) [*8])
		else $error("A1 run broken");
	a_a2_run: assert property (frame_pulse_o |-> ##16 (line_data_o == A2_VAL) [*8])
		else $error("A2 run broken");
	a_row0_clear: assert property (frame_pulse_o |-> ##28 (line_data_o == 8'h00) [*8])
		else $error("row 0 overhead scrambled");
	a_reset_quiet: assert property ($fell(sys_rst_i) |-> line_data_o == 8'h00 && !frame_pulse_o && cell_cnt_o == '0)
		else $error("outputs not cleared by reset");
	a_first_mark: assert property ($fell(sys_rst_i) |=> frame_pulse_o)
		else $error("no frame mark after reset");
	a_conc_single: assert property (conc_mode_i |-> cell_take_o[3:1] == 3'h0)
		else $error("idle processor took bytes");
	a_count_step: assert property (!$stable(cell_cnt_o[0].assigned)
		|-> cell_cnt_o[0].assigned == $past(cell_cnt_o[0].assigned) + 16'h0001)
		else $error("assigned count jumped");

	c_frame: cover property (frame_pulse_o);
	c_conc_frame: cover property (conc_mode_i && frame_pulse_o);
	c_idle_count: cover property (!$stable(cell_cnt_o[2].idle));
endmodule : sonet_tx_framer_chk

bind sonet_tx_framer sonet_tx_framer_chk u_chk (
	.clock_i       (clock_i),
	.sys_rst_i     (sys_rst_i),
	.conc_mode_i   (conc_mode_i),
	.cell_take_o   (cell_take_o),
	.line_data_o   (line_data_o),
	.frame_pulse_o (frame_pulse_o),
	.cell_cnt_o    (cell_cnt_o)
);

// ==== sim/test_atm_sonet_tx_convergence.sv ====
`timescale 1ns/1ps
module test_atm_sonet_tx_convergence
	import sonet_tx_pkg::*;
;
	localparam logic [31:0] USR_HDR = 32'h1234_5670;
	localparam logic [31:0] TST_HDR = 32'h00AB_CD00;
	localparam logic [31:0] IDL_HDR = 32'h0000_0001;
	localparam int          LIMIT   = 80000;

	logic             clock_i;
	logic             sys_rst_i;
	logic             conc_mode_i;
	logic [3:0]       test_en_i;
	logic [3:0]       gfc_en_i;
	logic [3:0][31:0] test_hdr_i;
	alarm_cmd_t       alarm_cmd_i;
	logic             rx_line_alarm_i;
	logic             rx_path_alarm_i;
	logic [3:0]       cell_avail_i;
	logic [3:0][7:0]  cell_data_i;
	logic [3:0]       cell_take_o;
	logic [7:0]       line_data_o;
	logic             frame_pulse_o;
	cell_cnt_t [3:0]  cell_cnt_o;
	cell_cnt_t [3:0]  snap;
	logic [3:0]       took;
	int               bidx [4];
	int               error_cnt    = 0;
	int               total_checks = 0;
	int               cyc          = 0;

	initial
	begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	sonet_tx_framer u_dut (
		.clock_i         (clock_i),
		.sys_rst_i       (sys_rst_i),
		.conc_mode_i     (conc_mode_i),
		.test_en_i       (test_en_i),
		.gfc_en_i        (gfc_en_i),
		.test_hdr_i      (test_hdr_i),
		.alarm_cmd_i     (alarm_cmd_i),
		.rx_line_alarm_i (rx_line_alarm_i),
		.rx_path_alarm_i (rx_path_alarm_i),
		.cell_avail_i    (cell_avail_i),
		.cell_data_i     (cell_data_i),
		.cell_take_o     (cell_take_o),
		.line_data_o     (line_data_o),
		.frame_pulse_o   (frame_pulse_o),
		.cell_cnt_o      (cell_cnt_o)
	);

	line_conv_model u_line (
		.clock_i       (clock_i),
		.line_data_i   (line_data_o),
		.frame_pulse_i (frame_pulse_o)
	);

	// Upstream buffers: endless user cells, next byte shown after each take
	always @(posedge clock_i)
		took <= sys_rst_i ? 4'h0 : cell_take_o; // Takes made in reset must not move the index
	always @(negedge clock_i)
		for (int c = 0; c < 4; c++)
		begin
			if (sys_rst_i)
				bidx[c] = 0;
			else if (took[c])
				bidx[c] = (bidx[c] == 51) ? 0 : bidx[c] + 1;
			cell_data_i[c] = (bidx[c] < 4) ? USR_HDR[31 - 8 * bidx[c] -: 8] : 8'(bidx[c]);
		end

	always @(posedge clock_i)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			error_cnt++;
			report_and_stop();
		end
	end

	task automatic report_and_stop;
		if (error_cnt == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : check

	task automatic next_frame;
		int f;
		f = u_line.frames;
		wait (u_line.frames != f);
		@(negedge clock_i);
	endtask : next_frame

	function automatic logic [15:0] at(input int r, input int c);
		return {8'h00, u_line.frm_mem[r * 1080 + c]};
	endfunction : at

	function automatic logic [7:0] hec(input logic [31:0] h);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 31; i >= 0; i--)
			r = {r[6:0], 1'b0} ^ ((r[7] ^ h[i]) ? 8'h07 : 8'h00);
		return r ^ 8'h55;
	endfunction : hec

	// Header plus check byte anywhere in one channel's payload bytes
	function automatic logic [15:0] seen(input logic [31:0] hdr, input int ch);
		logic [7:0]  s [$];
		logic [39:0] pat;
		pat = {hdr, hec(hdr)};
		for (int i = 0; i < 9720; i++)
			if (i % 1080 >= 40 && (conc_mode_i || i % 4 == ch))
				s.push_back(u_line.frm_mem[i]);
		for (int i = 0; i + 4 < s.size(); i++)
			if ({s[i], s[i + 1], s[i + 2], s[i + 3], s[i + 4]} === pat)
				return 16'h0001;
		return 16'h0000;
	endfunction : seen

	// One user cell's payload: each bit past the 43rd is clear bit xor the sent bit 43 back
	function automatic logic [15:0] scr_err(input int ch);
		logic [7:0]   s [$];
		logic [383:0] pay;
		logic [7:0]   clr;
		int           k;
		k = -1;
		for (int i = 0; i < 9720; i++)
			if (i % 1080 >= 40 && (conc_mode_i || i % 4 == ch))
				s.push_back(u_line.frm_mem[i]);
		for (int i = 0; k < 0 && i + 52 < s.size(); i++)
			if ({s[i], s[i + 1], s[i + 2], s[i + 3], s[i + 4]} === {USR_HDR, hec(USR_HDR)})
				k = i + 5;
		if (k < 0)
			return 16'h0001;
		for (int j = 0; j < 48; j++)
			pay[383 - 8 * j -: 8] = s[k + j];
		for (int n = 43; n < 384; n++)
		begin
			clr = 8'(4 + n / 8);
			if (pay[383 - n] !== (pay[426 - n] ^ clr[7 - n % 8]))
				return 16'h0001;
		end
		return 16'h0000;
	endfunction : scr_err

	task automatic check_ptr(input logic conc);
		logic first;
		for (int c = 0; c < 12; c++)
		begin
			first = conc ? (c == 0) : (c < 4);
			check(at(3, c), first ? 16'h0062 : 16'h0093, "H1");
			check(at(3, 12 + c), first ? 16'h000A : 16'h00FF, "H2");
		end
	endtask : check_ptr

	initial
	begin
		sys_rst_i       = 1'b1;
		conc_mode_i     = 1'b0;
		test_en_i       = 4'h0;
		gfc_en_i        = 4'h0;
		test_hdr_i      = {4{TST_HDR}};
		alarm_cmd_i     = 4'h0;
		rx_line_alarm_i = 1'b0;
		rx_path_alarm_i = 1'b0;
		cell_avail_i    = 4'hF;
		repeat (16) @(negedge clock_i);
		sys_rst_i = 1'b0;
		next_frame();
		next_frame();
		check_ptr(1'b0);
		for (int ch = 0; ch < 4; ch++)
		begin
			check(at(2, 36 + ch), 16'h0013, "C2");
			check(at(3, 36 + ch), 16'h0000, "G1 idle");
			check(seen(USR_HDR, ch), 16'h0001, "user cell");
			check(scr_err(ch), 16'h0000, "payload scramble");
		end
		// Path RDI by command, line RDI by receive alarm, mixed cell sources
		alarm_cmd_i     = 4'b0100;
		rx_line_alarm_i = 1'b1;
		cell_avail_i    = 4'b1001;
		test_en_i       = 4'b0010;
		gfc_en_i        = 4'b1000;
		repeat (400) @(negedge clock_i);
		snap = cell_cnt_o;
		next_frame();
		for (int ch = 0; ch < 4; ch++)
			check(at(3, 36 + ch), 16'h0008, "G1 RDI");
		check(at(4, 24), 16'h0006, "K2 RDI");
		check(seen(TST_HDR, 1), 16'h0001, "test cell");
		check(seen(IDL_HDR, 2), 16'h0001, "idle cell");
		check(seen(IDL_HDR, 3), 16'h0001, "idle under flow control");
		check(cell_cnt_o[1].idle, snap[1].idle, "test not idle");
		check(16'(cell_cnt_o[2].idle > snap[2].idle), 16'h0001, "idle count");
		check(cell_cnt_o[2].assigned, snap[2].assigned, "no user on empty");
		check(cell_cnt_o[3].assigned, snap[3].assigned, "flow halt");
		check(16'(cell_cnt_o[0].assigned > snap[0].assigned), 16'h0001, "assigned count");
		// Both alarm indication signals
		alarm_cmd_i     = 4'b1010;
		rx_line_alarm_i = 1'b0;
		cell_avail_i    = 4'hF;
		test_en_i       = 4'h0;
		gfc_en_i        = 4'h0;
		next_frame();
		for (int r = 0; r < 9; r++)
			for (int c = 0; c < 1080; c += 27)
				if (r >= 3 || c >= 36)
					check(at(r, c), 16'h00FF, "AIS");
		// Concatenated mode, chosen while in reset
		alarm_cmd_i = 4'h0;
		sys_rst_i   = 1'b1;
		conc_mode_i = 1'b1;
		repeat (16) @(negedge clock_i);
		sys_rst_i = 1'b0;
		next_frame();
		next_frame();
		check_ptr(1'b1);
		check(at(2, 36), 16'h0013, "C2 conc");
		for (int r = 0; r < 9; r++)
			for (int c = 37; c < 40; c++)
				check(at(r, c), 16'h0000, "fixed stuff");
		check(seen(USR_HDR, 0), 16'h0001, "conc cell");
		check(scr_err(0), 16'h0000, "conc scramble");
		check(cell_cnt_o[1].assigned | cell_cnt_o[1].idle, 16'h0000, "ch1 idle");
		report_and_stop();
	end
endmodule : test_atm_sonet_tx_convergence
